// File: fp_diff_pkg.sv
// Purpose: shared constants and carriers for the frame pulse and differential output block
// Assumes: one system clock at 125 MHz; byte-wide register port
// Notes: long counts derived here become top-level parameter defaults
package fp_diff_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int CLK_KHZ = 125000;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RATE = 8'h5B;
  localparam logic [7:0] ADDR_SHAPE = 8'h5C;
  localparam logic [7:0] ADDR_OFF_LOW = 8'h5D;
  localparam logic [7:0] ADDR_OFF_MID = 8'h5E;
  localparam logic [7:0] ADDR_OFF_COARSE = 8'h5F;
  localparam logic [7:0] ADDR_DIFF = 8'h60;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RATE = 8'h03;
  localparam logic [7:0] RST_SHAPE = 8'h03;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_DIFF = 8'hA3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RATE_LSB = 0;
  localparam int SHAPE_STYLE_BIT = 0;
  localparam int SHAPE_EDGE_BIT = 1;
  localparam int SHAPE_WIDTH_LSB = 4;
  localparam int SHAPE_POL_BIT = 7;
  localparam int COARSE_LSB = 0;
  localparam int DIFF_EN0_BIT = 0;
  localparam int DIFF_EN1_BIT = 1;
  localparam int DIFF_SKEW0_LSB = 4;
  localparam int DIFF_SKEW1_LSB = 6;
  localparam logic [2:0] WIDTH_CODE_SYNTH = 3'h7;
  localparam logic [2:0] RATE_CODE_64K = 3'h7;

  // ----------------------------------------------------------------
  // pulse widths, one period of each reference rate, rounded up
  // ----------------------------------------------------------------
  localparam int W0_KHZ = 19440;
  localparam int W1_KHZ = 38880;
  localparam int W2_KHZ = 77760;
  localparam int W3_KHZ = 155520;
  localparam int W4_KHZ = 6480;
  localparam int W5_KHZ = 51840;
  localparam int W0_CYC = (CLK_KHZ + W0_KHZ - 1) / W0_KHZ;
  localparam int W1_CYC = (CLK_KHZ + W1_KHZ - 1) / W1_KHZ;
  localparam int W2_CYC = (CLK_KHZ + W2_KHZ - 1) / W2_KHZ;
  localparam int W3_CYC = (CLK_KHZ + W3_KHZ - 1) / W3_KHZ;
  localparam int W4_CYC = (CLK_KHZ + W4_KHZ - 1) / W4_KHZ;
  localparam int W5_CYC = (CLK_KHZ + W5_KHZ - 1) / W5_KHZ;

  // ----------------------------------------------------------------
  // frame periods (ns) and their cycle counts
  // ----------------------------------------------------------------
  localparam int PER_166_NS = 6000000;
  localparam int PER_400_NS = 2500000;
  localparam int PER_1K_NS = 1000000;
  localparam int PER_2K_NS = 500000;
  localparam int PER_4K_NS = 250000;
  localparam int PER_8K_NS = 125000;
  localparam int PER_64K_NS = 15625;
  localparam int PER_166_CYC = PER_166_NS / CLK_NS;
  localparam int PER_400_CYC = PER_400_NS / CLK_NS;
  localparam int PER_1K_CYC = PER_1K_NS / CLK_NS;
  localparam int PER_2K_CYC = PER_2K_NS / CLK_NS;
  localparam int PER_4K_CYC = PER_4K_NS / CLK_NS;
  localparam int PER_8K_CYC = PER_8K_NS / CLK_NS;
  localparam int PER_64K_CYC = PER_64K_NS / CLK_NS;

  // ----------------------------------------------------------------
  // fine offset step, as a 16-bit fraction of one system cycle
  // ----------------------------------------------------------------
  localparam longint FINE_648_KHZ = 207360;
  localparam longint FINE_1944_KHZ = 311040;
  localparam longint FINE_FRAC_SCALE = 65536;
  localparam logic [19:0] FINE_K_648 = 20'((FINE_FRAC_SCALE * CLK_KHZ) / FINE_648_KHZ);
  localparam logic [19:0] FINE_K_1944 = 20'((FINE_FRAC_SCALE * CLK_KHZ) / FINE_1944_KHZ);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic data;
    logic oe;
  } diff_out_s;

endpackage

// File: diff_skew_out.sv
// Purpose: one differential output with enable and alignment skew
// Assumes: clk_in is a sampled synthesized clock, synchronous to sys_clk
// Notes: each skew step is one system cycle, coarser than the true step
`timescale 1ns/1ps
module diff_skew_out
  import fp_diff_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic clk_in,
  input wire logic enable,
  input wire logic [1:0] skew_code,
  // pin
  output diff_out_s pin
);

  typedef struct packed {
    logic [3:0] line;
    diff_out_s pin;
  } skew_state_s;

  skew_state_s st_reg;
  skew_state_s st_next;
  logic [5:0] hist_reg;

  always_comb
  begin
    st_next = st_reg;
    st_next.line = {st_reg.line[2:0], clk_in};
    // RULE13 RULE14 RULE16: skew tap
    st_next.pin.data = st_reg.line[skew_code];
    // RULE11 RULE12: enable or float
    st_next.pin.oe = enable;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pin = st_reg.pin;

  // history of the input for checking only
  always_ff @(posedge sys_clk)
  begin
    hist_reg <= {hist_reg[4:0], clk_in};
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  skew_tap_delay_a: assert property ( // RULE13
    $past(rst_n, 6) |-> pin.data == hist_reg[3'($past(skew_code)) + 3'h1])
    else $error("skew tap delay wrong");
  enable_follow_a: assert property ( // RULE11
    $past(rst_n) && $changed(enable) |=> pin.oe == $past(enable))
    else $error("enable not followed");
  skew_order_a: assert property ( // RULE14
    $past(rst_n, 6) && $past(skew_code) == 2'h0 |-> pin.data == hist_reg[1])
    else $error("lowest skew code not earliest");

endmodule

// File: frame_pulse_and_diff_out_ctrl.sv
// Purpose: register bank and output logic for the second frame pulse and the differential outputs
// Assumes: synthesized clocks arrive as levels synchronous to sys_clk
// Notes: sub-cycle steps are rounded to whole system cycles
// How it works
// RULE1: style bit picks a 50% duty clock or an aligned frame pulse.
// RULE2: edge bit starts the pulse on rising or falling synthesized clock edge.
// RULE3: width codes 000..101 give one period of the listed reference rates.
// RULE4: width code 111 makes the pulse one synthesized clock cycle wide.
// RULE5: polarity bit clear gives active high, set gives active low.
// RULE6: the phase offset is one 22-bit value over three byte registers.
// RULE7: low register holds offset bits 7:0, mid register bits 15:8.
// RULE8: for 6.48 MHz family each fine unit delays one 207.36 MHz period.
// RULE9: for 19.44 MHz family each fine unit delays one 311.04 MHz period.
// RULE10: coarse register bits 5:0 add whole 8 kHz cycles of delay.
// RULE11: control bit 0 enables first differential output, else it floats.
// RULE12: control bit 1 enables second differential output, else it floats.
// RULE13: bits 5:4 shift first differential output against first clock.
// RULE14: lower skew codes advance, higher codes retard the output.
// RULE15: rate field selects frame pulse rate from 166.67 Hz to 64 kHz.
// RULE16: bits 7:6 skew the second differential output, lower codes advance.
// RULE17: software keeps reserved bits default and writes all offset bytes.
`timescale 1ns/1ps
module frame_pulse_and_diff_out_ctrl
  import fp_diff_pkg::*;
#(
  parameter int PERIOD_166_CYC = PER_166_CYC,
  parameter int PERIOD_400_CYC = PER_400_CYC,
  parameter int PERIOD_1K_CYC = PER_1K_CYC,
  parameter int PERIOD_2K_CYC = PER_2K_CYC,
  parameter int PERIOD_4K_CYC = PER_4K_CYC,
  parameter int PERIOD_8K_CYC = PER_8K_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input reg_req_s bus_req,
  output logic [7:0] rd_data,
  // synthesized clocks
  input wire logic first_synth_clock,
  input wire logic second_synth_clock,
  input wire logic second_clock_family_648,
  // outputs
  output logic second_frame_pulse_out,
  output diff_out_s first_diff_output,
  output diff_out_s second_diff_output
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rate_reg;
    logic [7:0] shape_reg;
    logic [7:0] off_low_reg;
    logic [7:0] off_mid_reg;
    logic [7:0] off_coarse_reg;
    logic [7:0] diff_reg;
    logic [21:0] offset_live;
    logic [19:0] frame_cnt;
    logic [19:0] target;
    logic [19:0] phase_cnt;
    logic [4:0] width_cnt;
    logic armed;
    logic active;
    logic clk_prev;
    logic pulse_out;
    logic [7:0] rd_data;
  } state_s;

  localparam state_s ST_RESET = '{
    rate_reg: RST_RATE,
    shape_reg: RST_SHAPE,
    off_low_reg: RST_OFFSET,
    off_mid_reg: RST_OFFSET,
    off_coarse_reg: RST_OFFSET,
    diff_reg: RST_DIFF,
    default: '0
  };

  state_s st_reg;
  state_s st_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // RULE15: rate to frame period
  function automatic logic [19:0] period_cycles(input logic [2:0] code);
    logic [19:0] p;
    p = 20'(PERIOD_8K_CYC);
    unique case (code)
      3'h0: p = 20'(PERIOD_166_CYC);
      3'h1: p = 20'(PERIOD_400_CYC);
      3'h2: p = 20'(PERIOD_1K_CYC);
      3'h3: p = 20'(PERIOD_2K_CYC);
      3'h4: p = 20'(PERIOD_4K_CYC);
      3'h5: p = 20'(PERIOD_8K_CYC);
      3'h6: p = 20'(PERIOD_8K_CYC);
      3'h7: p = 20'(PER_64K_CYC);
    endcase
    return p;
  endfunction

  // RULE3: width code to cycles
  function automatic logic [4:0] width_cycles(input logic [2:0] code);
    logic [4:0] w;
    w = 5'(W0_CYC);
    unique case (code)
      3'h0: w = 5'(W0_CYC);
      3'h1: w = 5'(W1_CYC);
      3'h2: w = 5'(W2_CYC);
      3'h3: w = 5'(W3_CYC);
      3'h4: w = 5'(W4_CYC);
      3'h5: w = 5'(W5_CYC);
      3'h6: w = 5'(W0_CYC);
      3'h7: w = 5'h01;
    endcase
    return w;
  endfunction

  // position of the pulse within the frame
  function automatic logic [19:0] delay_target(input logic [21:0] off, input logic fam648,
                                               input logic [19:0] period);
    logic [35:0] fine_prod;
    logic [19:0] total;
    // RULE8 RULE9: fine step by family
    fine_prod = 36'(off[15:0]) * 36'(fam648 ? FINE_K_648 : FINE_K_1944);
    // RULE10: coarse in 8 kHz cycles
    total = 20'(off[21:16]) * 20'(PERIOD_8K_CYC);
    total = total + 20'(fine_prod >> 16);
    return total % period;
  endfunction

  // ----------------------------------------------------------------
  // decoded fields
  // ----------------------------------------------------------------
  logic style_pulse;
  logic edge_fall;
  logic [2:0] width_code;
  logic pol_low;
  logic [2:0] rate_code;
  logic [19:0] period;
  logic rise;
  logic fall;
  logic sync_edge;
  logic start;
  logic level;

  assign style_pulse = st_reg.shape_reg[SHAPE_STYLE_BIT];
  assign edge_fall = st_reg.shape_reg[SHAPE_EDGE_BIT];
  assign width_code = st_reg.shape_reg[SHAPE_WIDTH_LSB +: 3];
  assign pol_low = st_reg.shape_reg[SHAPE_POL_BIT];
  assign rate_code = st_reg.rate_reg[RATE_LSB +: 3];
  assign period = period_cycles(rate_code);
  assign rise = second_synth_clock & ~st_reg.clk_prev;
  assign fall = ~second_synth_clock & st_reg.clk_prev;
  // RULE2: chosen sync edge
  assign sync_edge = edge_fall ? fall : rise;
  assign start = st_reg.armed & sync_edge;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    level = 1'b0;
    st_next.clk_prev = second_synth_clock;
    st_next.rd_data = 8'h00;

    // read data stands only in the cycle after the strobe
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        ADDR_RATE: st_next.rd_data = st_reg.rate_reg;
        ADDR_SHAPE: st_next.rd_data = st_reg.shape_reg;
        ADDR_OFF_LOW: st_next.rd_data = st_reg.off_low_reg;
        ADDR_OFF_MID: st_next.rd_data = st_reg.off_mid_reg;
        ADDR_OFF_COARSE: st_next.rd_data = st_reg.off_coarse_reg;
        ADDR_DIFF: st_next.rd_data = st_reg.diff_reg;
        default: st_next.rd_data = 8'h00;
      endcase
    end

    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        ADDR_RATE: st_next.rate_reg = bus_req.wdata;
        ADDR_SHAPE: st_next.shape_reg = bus_req.wdata;
        // RULE7: fine bytes
        ADDR_OFF_LOW: st_next.off_low_reg = bus_req.wdata;
        ADDR_OFF_MID: st_next.off_mid_reg = bus_req.wdata;
        ADDR_OFF_COARSE:
        begin
          st_next.off_coarse_reg = bus_req.wdata;
          // RULE6 RULE17: commit whole offset
          // taking all 22 bits at once keeps a half-written offset off the pin
          st_next.offset_live = {bus_req.wdata[COARSE_LSB +: 6], st_reg.off_mid_reg,
                                 st_reg.off_low_reg};
        end
        ADDR_DIFF: st_next.diff_reg = bus_req.wdata;
        default:
        begin
        end
      endcase
    end

    // registered to keep the divider off the pulse path
    st_next.target = delay_target(st_reg.offset_live, second_clock_family_648, period);

    // RULE15: frame counter
    if (st_reg.frame_cnt >= period - 20'h1)
    begin
      st_next.frame_cnt = 20'h0;
    end
    else
    begin
      st_next.frame_cnt = st_reg.frame_cnt + 20'h1;
    end

    if (st_reg.frame_cnt == st_reg.target)
    begin
      st_next.armed = 1'b1;
    end

    if (st_reg.phase_cnt != 20'hFFFFF)
    begin
      st_next.phase_cnt = st_reg.phase_cnt + 20'h1;
    end

    if (start)
    begin
      st_next.armed = 1'b0;
      st_next.active = 1'b1;
      st_next.phase_cnt = 20'h0;
      st_next.width_cnt = width_cycles(width_code) - 5'h1;
    end
    else if (st_reg.active)
    begin
      if (width_code == WIDTH_CODE_SYNTH)
      begin
        // RULE4: one synthesized cycle
        if (sync_edge)
        begin
          st_next.active = 1'b0;
        end
      end
      else if (st_reg.width_cnt == 5'h0)
      begin
        // RULE3: width elapsed
        st_next.active = 1'b0;
      end
      else
      begin
        st_next.width_cnt = st_reg.width_cnt - 5'h1;
      end
    end

    // RULE1: clock style or frame pulse
    if (st_next.shape_reg[SHAPE_STYLE_BIT])
    begin
      level = st_next.active;
    end
    else
    begin
      level = st_next.phase_cnt < (period_cycles(st_next.rate_reg[RATE_LSB +: 3]) >> 1);
    end
    // RULE5: polarity
    st_next.pulse_out = level ^ st_next.shape_reg[SHAPE_POL_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign second_frame_pulse_out = st_reg.pulse_out;

  // ----------------------------------------------------------------
  // differential outputs
  // ----------------------------------------------------------------
  diff_skew_out u_first_diff (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_in(first_synth_clock),
    .enable(st_reg.diff_reg[DIFF_EN0_BIT]),
    .skew_code(st_reg.diff_reg[DIFF_SKEW0_LSB +: 2]),
    .pin(first_diff_output)
  );

  diff_skew_out u_second_diff (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_in(second_synth_clock),
    .enable(st_reg.diff_reg[DIFF_EN1_BIT]),
    .skew_code(st_reg.diff_reg[DIFF_SKEW1_LSB +: 2]),
    .pin(second_diff_output)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  clock_style_a: assert property ( // RULE1
    !style_pulse && $past(!style_pulse) |->
      second_frame_pulse_out == ((st_reg.phase_cnt < (period >> 1)) ^ pol_low))
    else $error("clock style level wrong");
  start_edge_a: assert property ( // RULE2
    $rose(st_reg.active) |-> $past(edge_fall ? fall : rise) && $past(st_reg.armed))
    else $error("pulse started off the chosen edge");
  width_000_a: assert property ( // RULE3
    $rose(st_reg.active) && width_code == 3'h0 && $stable(st_reg.shape_reg)
      |-> st_reg.active [*7] ##1 !st_reg.active)
    else $error("code 000 width not seven cycles");
  synth_width_a: assert property ( // RULE4
    st_reg.active && width_code == WIDTH_CODE_SYNTH && sync_edge && !st_reg.armed
      |=> !st_reg.active)
    else $error("code 111 pulse outlived its cycle");
  polarity_a: assert property ( // RULE5
    style_pulse |-> second_frame_pulse_out == (st_reg.active ^ pol_low))
    else $error("pulse polarity wrong");
  offset_commit_a: assert property ( // RULE6
    bus_req.wr && bus_req.addr == ADDR_OFF_COARSE |=>
      st_reg.offset_live == {$past(bus_req.wdata[5:0]), $past(st_reg.off_mid_reg),
                             $past(st_reg.off_low_reg)})
    else $error("offset not committed whole");
  mid_readback_a: assert property ( // RULE7
    bus_req.wr && bus_req.addr == ADDR_OFF_MID ##1 bus_req.rd && bus_req.addr == ADDR_OFF_MID
      |=> rd_data == $past(bus_req.wdata, 2))
    else $error("mid offset byte readback wrong");
  fine_648_a: assert property ( // RULE8
    st_reg.offset_live == 22'h000064 && second_clock_family_648 && rate_code == 3'h0
      |=> st_reg.target == 20'd60)
    else $error("fine step for 6.48 family wrong");
  fine_1944_a: assert property ( // RULE9
    st_reg.offset_live == 22'h000064 && !second_clock_family_648 && rate_code == 3'h0
      |=> st_reg.target == 20'd40)
    else $error("fine step for 19.44 family wrong");
  coarse_step_a: assert property ( // RULE10
    st_reg.offset_live[15:0] == 16'h0 && rate_code == 3'h0 && $stable(st_reg.offset_live)
      |=> st_reg.target == 20'($past(st_reg.offset_live[21:16])) * 20'(PERIOD_8K_CYC)
                           % 20'(PERIOD_166_CYC))
    else $error("coarse offset wrong");
  frame_wrap_a: assert property ( // RULE15
    st_reg.frame_cnt == period - 20'h1 |=> st_reg.frame_cnt == 20'h0)
    else $error("frame counter did not wrap at its period");
  diff_enable_a: assert property ( // RULE12
    $past(rst_n) |-> second_diff_output.oe == $past(st_reg.diff_reg[DIFF_EN1_BIT]))
    else $error("second differential enable wrong");

  pulse_start_c: cover property ($rose(st_reg.active) && style_pulse);
  synth_pulse_c: cover property ($fell(st_reg.active) && width_code == WIDTH_CODE_SYNTH);
  clock_style_c: cover property (!style_pulse && $rose(second_frame_pulse_out));
  offset_commit_c: cover property (bus_req.wr && bus_req.addr == ADDR_OFF_COARSE);

endmodule

// File: synth_clock_source.sv
// Purpose: sampled synthesized clock levels feeding the frame pulse and diff output block
// Assumes: levels change only just after a sys_clk rising edge
// Notes: a six-cycle first clock keeps skew delays of two to five cycles apart
`timescale 1ns/1ps
module synth_clock_source #(
  parameter int HALF_FIRST = 3,
  parameter int HALF_SECOND = 2
)
(
  // clock
  input wire logic sys_clk,
  // synthesized clock levels
  output logic first_synth_clock,
  output logic second_synth_clock
);
  int cnt_first = 0;
  int cnt_second = 0;

  initial
  begin
    first_synth_clock = 1'b0;
    second_synth_clock = 1'b0;
  end

  // free running, the synthesizers never stop between frames
  always @(posedge sys_clk)
  begin
    cnt_first <= (cnt_first == HALF_FIRST - 1) ? 0 : cnt_first + 1;
    cnt_second <= (cnt_second == HALF_SECOND - 1) ? 0 : cnt_second + 1;
    if (cnt_first == HALF_FIRST - 1)
      first_synth_clock <= ~first_synth_clock;
    if (cnt_second == HALF_SECOND - 1)
      second_synth_clock <= ~second_synth_clock;
  end
endmodule

// File: frame_pulse_and_diff_out_ctrl_tb.sv
// Purpose: self-checking bench for the frame pulse and diff output block
// Assumes: second clock period 4 cycles, frame periods shortened to 600..100 cycles, the 64 kHz one kept at 1953
// Notes: pulse timing is judged by differences of start times, never by absolute phase
`timescale 1ns/1ps
module frame_pulse_and_diff_out_ctrl_tb;
  import fp_diff_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_s bus_req = '0;
  logic family_648 = 1'b1;
  logic [7:0] rd_data;
  logic first_synth_clock;
  logic second_synth_clock;
  logic second_frame_pulse_out;
  diff_out_s first_diff_output;
  diff_out_s second_diff_output;
  logic [15:0] hist_first = '0;
  logic [15:0] hist_second = '0;
  logic pol_now = 1'b0;
  int cyc = 0;
  int n_errors = 0;
  int n_compared = 0;
  localparam int FRAME_8K_CYC = 100;
  logic [7:0] addrs[6] = '{8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h60};
  logic [7:0] rstv[6] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'hA3};
  logic [7:0] pat[6] = '{8'h05, 8'hF3, 8'h5A, 8'hA5, 8'h2A, 8'h53};
  int wexp[8] = '{7, 4, 2, 1, 20, 3, 7, 4};
  int pexp[8] = '{600, 500, 400, 300, 200, 100, 100, 1953};

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    hist_first <= {hist_first[14:0], first_synth_clock};
    hist_second <= {hist_second[14:0], second_synth_clock};
  end

  frame_pulse_and_diff_out_ctrl #(
    .PERIOD_166_CYC(600), .PERIOD_400_CYC(500), .PERIOD_1K_CYC(400),
    .PERIOD_2K_CYC(300), .PERIOD_4K_CYC(200), .PERIOD_8K_CYC(FRAME_8K_CYC)
  ) u_frame_pulse_and_diff_out_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
    .first_synth_clock(first_synth_clock), .second_synth_clock(second_synth_clock),
    .second_clock_family_648(family_648), .second_frame_pulse_out(second_frame_pulse_out),
    .first_diff_output(first_diff_output), .second_diff_output(second_diff_output)
  );

  synth_clock_source u_synth_clock_source (
    .sys_clk(sys_clk), .first_synth_clock(first_synth_clock),
    .second_synth_clock(second_synth_clock)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk($sformatf("register %0h", a), {24'h0, rd_data}, {24'h0, exp});
  endtask

  // write and read back on consecutive cycles, no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    rd_chk(a, d);
  endtask

  function automatic logic act();
    return second_frame_pulse_out ^ pol_now;
  endfunction

  task automatic next_start(output int t);
    logic prev;
    int i;
    prev = act();
    for (i = 0; i < 4000; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (act() && !prev)
        break;
      prev = act();
    end
    if (i == 4000)
      chk("pulse start", 0, 1);
    t = cyc;
  endtask

  task automatic pulse_width(output int w);
    int t;
    next_start(t);
    w = 1;
    while (act() && w < 200)
    begin
      @(posedge sys_clk);
      #1;
      if (act())
        w++;
    end
  endtask

  // a write to the shape register, then wait for the next pulse start
  task automatic shape(input logic pol, input logic [2:0] code, input logic edge_fall,
                       input logic style);
    int t;
    wr(ADDR_SHAPE, {pol, code, 2'b00, edge_fall, style});
    pol_now = pol;
    next_start(t);
  endtask

  task automatic offset_delta(input logic [7:0] lo, input logic [7:0] coarse, input int base,
                              input bit commit, input int exp);
    int t;
    wr(ADDR_OFF_LOW, lo);
    wr(ADDR_OFF_MID, 8'h00);
    if (commit)
      wr(ADDR_OFF_COARSE, coarse);
    next_start(t);
    next_start(t);
    chk("offset delta", (t - base) % 600, exp);
  endtask

  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    int t0;
    int t1;
    int t2;
    int w;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("oe in reset", {first_diff_output.oe, second_diff_output.oe}, 2'b00);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // --------------------------------------------------------------
    // register bank
    // --------------------------------------------------------------
    for (int i = 0; i < 6; i++)
      rd_chk(addrs[i], rstv[i]);
    chk("oe after reset", {first_diff_output.oe, second_diff_output.oe}, 2'b11);
    // reserved bits kept at their defaults in every pattern
    for (int i = 0; i < 6; i++)
      wr(addrs[i], pat[i]);
    for (int i = 0; i < 6; i++)
      rd_chk(addrs[i], pat[i]);
    wr(8'h61, 8'hFF);
    rd_chk(8'h61, 8'h00);
    rd_chk(8'h5A, 8'h00);
    wr_rd(ADDR_OFF_MID, 8'h3C);
    for (int i = 0; i < 6; i++)
      wr(addrs[i], rstv[i]);
    // --------------------------------------------------------------
    // differential outputs
    // --------------------------------------------------------------
    for (int e = 0; e < 4; e++)
    begin
      wr(ADDR_DIFF, {6'h00, e[1:0]});
      repeat (3) @(posedge sys_clk);
      #1;
      chk("first oe", first_diff_output.oe, e[0]);
      chk("second oe", second_diff_output.oe, e[1]);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_DIFF, {c[1:0], c[1:0], 4'h3});
      repeat (5) @(posedge sys_clk);
      for (int k = 0; k < 6; k++)
      begin
        @(negedge sys_clk);
        chk("first skew", first_diff_output.data, hist_first[1 + c]);
        chk("second skew", second_diff_output.data, hist_second[1 + c]);
      end
    end
    wr(ADDR_DIFF, 8'hA3);
    // --------------------------------------------------------------
    // frame pulse shape, rate 8 kHz code gives 100 cycles
    // --------------------------------------------------------------
    wr(ADDR_RATE, 8'h05);
    for (int p = 0; p < 2; p++)
      for (int code = 0; code < 8; code++)
      begin
        shape(p[0], code[2:0], 1'b0, 1'b1);
        pulse_width(w);
        chk($sformatf("width code %0d", code), w, wexp[code]);
      end
    shape(1'b0, 3'h7, 1'b1, 1'b1);
    pulse_width(w);
    chk("synth cycle width", w, 4);
    shape(1'b0, 3'h0, 1'b0, 1'b0);
    pulse_width(w);
    chk("clock style high", w, 50);
    shape(1'b0, 3'h3, 1'b0, 1'b1);
    next_start(t0);
    shape(1'b0, 3'h3, 1'b1, 1'b1);
    next_start(t1);
    chk("edge select shift", (t1 - t0) % 4, 2);
    shape(1'b1, 3'h3, 1'b0, 1'b1);
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_RATE, r[7:0]);
      next_start(t0);
      next_start(t1);
      next_start(t2);
      if (r == 7)
        chk("64k period", (t2 - t1 >= 1950) && (t2 - t1 <= 1956), 1);
      else
        chk($sformatf("rate code %0d", r), t2 - t1, pexp[r]);
    end
    // --------------------------------------------------------------
    // phase offset, rate code 000 gives 600 cycles
    // --------------------------------------------------------------
    wr(ADDR_RATE, 8'h00);
    family_648 <= 1'b1;
    next_start(t0);
    next_start(t0);
    offset_delta(8'h64, 8'h00, t0, 1'b0, 0);
    offset_delta(8'h64, 8'h00, t0, 1'b1, 60);
    @(posedge sys_clk);
    family_648 <= 1'b0;
    offset_delta(8'h64, 8'h00, t0, 1'b1, 40);
    offset_delta(8'h00, 8'h01, t0, 1'b1, 100);
    report_and_stop();
  end
endmodule
